// [tb/i2c_host_model.sv]
// Purpose: host access model. Assumes: one-cycle strobes. Notes: idle data inverted.
`timescale 1ns/1ps
module i2c_host_model (input wire clk, regRvalid_ff, input wire [7:0] regRdata_ff,
    output reg regWrite = 1'h0, regRead = 1'h0, output reg [7:0] regAddr = 8'h00, regWdata = 8'h00);
    task wr(input [7:0] a, d);
        @(posedge clk) {regAddr, regWdata, regWrite} <= {a, d, 1'h1};
        @(posedge clk) {regWdata, regWrite} <= {~d, 1'h0};
    endtask
    task rd(input [7:0] a, output [7:0] d);
        @(posedge clk) {regAddr, regRead} <= {a, 1'h1};
        @(posedge clk) regRead <= 1'h0;
        @(posedge clk) d = regRvalid_ff ? regRdata_ff : 8'hXX;
    endtask
endmodule

// [tb/i2c_target_address_select_props.sv]
// Purpose: port checks. Assumes: one clock. Notes: select and strap mirrored.
`timescale 1ns/1ps
module i2c_target_address_select_props #(parameter FLAG_COUNT = 8) (
    input wire clk, resetn, regWrite, regRead, regRvalid_ff,
    input wire [6:0] strapAddr, targetAddr_ff, input wire [7:0] regAddr, regWdata, regRdata_ff,
    input wire [FLAG_COUNT-1:0] hwSet, hwClear);
    reg sel_ff, rst_ff;
    reg [6:0] strap_ff;
    wire cfgWr = regWrite && regAddr == 8'h00;
    wire flgRd = regRead && regAddr == 8'h01 && !regWrite;
    always @(posedge clk) begin
        rst_ff <= !resetn;
        sel_ff <= resetn && (cfgWr ? regWdata[0] : sel_ff);
        if (rst_ff) strap_ff <= strapAddr;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_read_answer: assert property ($past(resetn) |-> regRvalid_ff == $past(regRead))
        else $error("slot");
    a_cfg_in_use: assert property (regRead && regAddr == 8'h00 && !$past(regWrite) |=>
        regRdata_ff == {$past(targetAddr_ff), $past(sel_ff)}) else $error("cfg");
    a_strap_in_use: assert property (!sel_ff && !$past(sel_ff) && !$past(sel_ff, 2) &&
        $past(resetn, 2) |-> targetAddr_ff == strap_ff) else $error("strap");
    a_prog_in_use: assert property (cfgWr && sel_ff && regWdata[0] ##1 !regWrite |=>
        targetAddr_ff == $past(regWdata[7:1], 2)) else $error("prog");
    a_read_clears: assert property (flgRd && hwSet == 0 ##1 (!regWrite && hwSet == 0) [*2]
        ##1 flgRd |=> regRdata_ff == 8'h00) else $error("clear");
    a_hw_sets: assert property (hwSet[0] && !hwClear[0] ##1 !hwClear[0] && !regRead ##1 flgRd
        |=> regRdata_ff[0]) else $error("set");
    a_write_sets: assert property (regWrite && regAddr == 8'h01 && regWdata[7] && !hwClear[7]
        ##1 !regRead && !hwClear[7] ##1 flgRd |=> regRdata_ff[7]) else $error("w1s");
endmodule

// [tb/tb.sv]
// Purpose: scenario bench. Assumes: 5 ns clock. Notes: flag bits 0 and 7 used.
`timescale 1ns/1ps
module tb;
    reg clk = 1'h0, resetn = 1'h0;
    reg [6:0] strapAddr = 7'h3D;
    reg [7:0] hwSet = 8'h00, hwClear = 8'h00, d;
    wire [7:0] regAddr, regWdata, regRdata_ff;
    wire [6:0] targetAddr_ff;
    wire regWrite, regRead, regRvalid_ff;
    integer fails = 0, check_count = 0;
    always #2.5 clk = ~clk;
    i2c_target_address_select i2c_target_address_select_inst (.*);
    i2c_host_model host (.*);
    task chk(input [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task t_addr;
        chk({targetAddr_ff, 1'h0}, {strapAddr, 1'h0});
        host.wr(8'h00, 8'hA4);
        host.rd(8'h00, d);
        chk(d, {strapAddr, 1'h0});
        host.wr(8'h00, 8'h01);
        host.wr(8'h00, 8'hA5);
        host.rd(8'h00, d);
        chk(d, 8'hA5);
        chk({targetAddr_ff, 1'h0}, 8'hA4);
        host.wr(8'h00, 8'h00);
        host.rd(8'h00, d);
        chk(d, {strapAddr, 1'h0});
        chk({targetAddr_ff, 1'h0}, {strapAddr, 1'h0});
        $display("address test done");
    endtask
    task t_flag;
        @(posedge clk) hwSet <= 8'h01;
        @(posedge clk) hwSet <= 8'h00;
        host.rd(8'h01, d);
        chk(d, 8'h01);
        host.rd(8'h01, d);
        chk(d, 8'h00);
        host.wr(8'h01, 8'h80);
        host.rd(8'h01, d);
        chk(d, 8'h80);
        @(posedge clk) hwSet <= 8'h01;
        @(posedge clk) {hwSet, hwClear} <= {8'h00, 8'h01};
        @(posedge clk) hwClear <= 8'h00;
        host.rd(8'h01, d);
        chk(d, 8'h00);
        $display("flag test done");
    endtask
    task end_of_test;
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'h1;
        repeat (3) @(posedge clk);
        t_addr;
        t_flag;
        end_of_test;
    end
    initial begin
        #2000 fails++;
        end_of_test;
    end
endmodule
bind i2c_target_address_select i2c_target_address_select_props #(.FLAG_COUNT(FLAG_COUNT)) p (.*);

// [verilog/access_type_field.v]
// Purpose: One register bit with hardware set, clear-on-read and write-one-set.
// Assumes: Read and write strobes are one-cycle pulses.
// Notes: A hardware set in the clearing cycle wins.
`timescale 1ns/1ps
module access_type_field (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Host side
    input wire readStb,
    input wire writeStb,
    input wire writeBit,
    // Hardware side
    input wire hwSet,
    input wire hwClear,
    // State
    output reg bit_ff
);
    reg nxt_bit;
    always @* begin
        nxt_bit = bit_ff;
        if (readStb) begin
            nxt_bit = 1'b0;
        end
        if (writeStb && writeBit) begin
            nxt_bit = 1'b1;
        end
        if (hwClear) begin
            nxt_bit = 1'b0;
        end
        if (hwSet) begin
            nxt_bit = 1'b1;
        end
    end
    always @(posedge clk) begin
        if (!resetn) begin
            bit_ff <= 1'b0;
        end else begin
            bit_ff <= nxt_bit;
        end
    end
endmodule

// [verilog/i2c_target_address_regs.vh]
// Purpose: Constants for the target address configuration register.
// Assumes: Two 8-bit registers, at offsets 0x0 and 0x1, reached over the I2C register port.
// Notes: Address field in bits 7:1, source select in bit 0.
// How it works
// - Bits 7:1 always read the address in use.
// - Select clear: field read-only, shows strapped address.
// - Select set: host writes load the field.
// - Respond at programmed address when select set.
// - Strap-loaded fields load from bootstrap pins in the first cycle after reset release.
// - Hardware-updated fields change independent of host writes.
`ifndef I2C_TARGET_ADDRESS_REGS_VH
`define I2C_TARGET_ADDRESS_REGS_VH
`define ADDR_CFG_OFFSET 8'h00
`define ADDR_FIELD_MSB 7
`define ADDR_FIELD_LSB 1
`define ADDR_SEL_BIT 0
`define ADDR_CFG_RESET 8'h00
`define ADDR_SEL_RESET 1'h0
`define FLAG_CFG_OFFSET 8'h01
`define FLAG_CFG_RESET 8'h00
`endif

// [verilog/i2c_target_address_select.v]
// Purpose: Holds and selects the device's own 7-bit I2C target address.
// Assumes: Register access strobes are synchronous one-cycle pulses.
// Notes: Reads answer one cycle after the strobe.
`timescale 1ns/1ps
`include "i2c_target_address_regs.vh"
module i2c_target_address_select #(
    parameter FLAG_COUNT = 8
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Bootstrap pins
    input wire [6:0] strapAddr,
    // Register access
    input wire [7:0] regAddr,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata_ff,
    output reg regRvalid_ff,
    // Hardware event flags
    input wire [FLAG_COUNT-1:0] hwSet,
    input wire [FLAG_COUNT-1:0] hwClear,
    // Address in use
    output reg [6:0] targetAddr_ff
);
    ////////////////////////////////////////////////////////////////////////
    // Strap capture after reset release.
    reg resetSeen_ff;
    reg [6:0] strapCap_ff;
    always @(posedge clk) begin
        if (!resetn) begin
            resetSeen_ff <= 1'b0;
            strapCap_ff <= 7'h00;
        end else begin
            resetSeen_ff <= 1'b1;
            if (!resetSeen_ff) begin
                strapCap_ff <= strapAddr;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Address register.
    reg [6:0] progAddr_ff;
    reg sourceSel_ff;
    wire hitCfg;
    wire hitFlag;
    assign hitCfg = (regAddr == `ADDR_CFG_OFFSET);
    assign hitFlag = (regAddr == `FLAG_CFG_OFFSET);
    always @(posedge clk) begin
        if (!resetn) begin
            sourceSel_ff <= `ADDR_SEL_RESET;
            progAddr_ff <= 7'h00;
        end else if (!resetSeen_ff) begin
            progAddr_ff <= strapAddr;
        end else if (regWrite && hitCfg) begin
            sourceSel_ff <= regWdata[`ADDR_SEL_BIT];
            if (sourceSel_ff) begin
                progAddr_ff <= regWdata[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];
            end
        end else if (!sourceSel_ff) begin
            progAddr_ff <= strapCap_ff;
        end
    end
    wire [6:0] addrInUse;
    assign addrInUse = sourceSel_ff ? progAddr_ff : strapCap_ff;
    ////////////////////////////////////////////////////////////////////////
    // Hardware-updated flag bits.
    wire [FLAG_COUNT-1:0] flagBits;
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi = gi + 1) begin : gFlag
            access_type_field uField (
                .clk(clk),
                .resetn(resetn),
                .readStb(regRead && hitFlag),
                .writeStb(regWrite && hitFlag),
                .writeBit(regWdata[gi]),
                .hwSet(hwSet[gi]),
                .hwClear(hwClear[gi]),
                .bit_ff(flagBits[gi])
            );
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////
    // Read path and outputs.
    always @(posedge clk) begin
        if (!resetn) begin
            regRdata_ff <= `ADDR_CFG_RESET;
            regRvalid_ff <= 1'b0;
            targetAddr_ff <= 7'h00;
        end else begin
            regRvalid_ff <= regRead;
            targetAddr_ff <= addrInUse;
            if (regRead && hitCfg) begin
                regRdata_ff <= {addrInUse, sourceSel_ff};
            end else if (regRead && hitFlag) begin
                regRdata_ff <= flagBits;
            end else if (regRead) begin
                regRdata_ff <= 8'h00;
            end
        end
    end
endmodule
